// ==== ddr_link_pkg.sv ====
package ddr_link_pkg;

	// ************************************************************
	// Link geometry
	// ************************************************************
	localparam int DATA_W = 64; // Data lanes
	localparam int CHECK_W = 8; // Check-bit lanes
	localparam int WORD_W = 72; // Data plus check bits
	localparam int LANES = 9; // Byte lanes, check lane last
	localparam int ROW_W = 13; // Row address width
	localparam int BANKS = 4; // Internal banks
	localparam int AP_BIT = 10; // Auto-precharge address line
	localparam int COL_HI_BIT = 11; // Upper column address line

	// ************************************************************
	// Mode word layout and reset values
	// ************************************************************
	localparam int MODE_BL_LSB = 0; // Burst length code, 3 bits
	localparam int MODE_BT_BIT = 3; // Set for interleaved order
	localparam int MODE_CL_LSB = 4; // Read latency code, 3 bits
	localparam logic [2:0] BL_CODE_2 = 3'h1;
	localparam logic [2:0] BL_CODE_4 = 3'h2;
	localparam logic [2:0] BL_CODE_8 = 3'h3;
	localparam logic [2:0] CL_CODE_2 = 3'h2;
	localparam logic [2:0] CL_CODE_25 = 3'h6;
	localparam logic [3:0] LAT_HALF_2 = 4'h4; // Latency 2, in half cycles
	localparam logic [3:0] LAT_HALF_25 = 4'h5; // Latency 2.5
	localparam logic [3:0] RESET_BEATS = 4'h2; // Burst of two after reset
	localparam logic [3:0] RESET_LAT = 4'h4; // Latency 2 after reset

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_NS = 10; // System clock period
	localparam logic [2:0] PH_FALL = 3'h4; // Link clock low from here
	localparam logic [2:0] PH_DECIDE = 3'h3; // Pins change after this
	localparam logic [2:0] PH_TOGGLE_A = 3'h1; // Strobe flips after this
	localparam logic [2:0] PH_TOGGLE_B = 3'h5;
	localparam logic [2:0] PH_LOAD_B = 3'h7; // Second data slot
	localparam int REFRESH_NS = 7800; // Longest average refresh gap
	localparam logic [9:0] REFRESH_COUNT = 10'(REFRESH_NS / CLK_NS);

	// Command code as {row, column, write} strobes, all active low
	typedef enum logic [2:0] {
		CMD_MODE = 3'h0,
		CMD_REFRESH = 3'h1,
		CMD_PRECHARGE = 3'h2,
		CMD_ACTIVATE = 3'h3,
		CMD_WRITE = 3'h4,
		CMD_READ = 3'h5,
		CMD_NOP = 3'h7
	} cmd_t;

	// Beats per burst from the mode code
	function automatic logic [3:0] beats_of(input logic [2:0] code);
		case (code)
			BL_CODE_4: beats_of = 4'h4;
			BL_CODE_8: beats_of = 4'h8;
			default: beats_of = 4'h2;
		endcase
	endfunction : beats_of

	// Low column bits of beat i, wrapping inside the burst block
	function automatic logic [2:0] burst_col(input logic [2:0] start,
		input logic [2:0] i, input logic [3:0] beats, input logic inter);
		logic [2:0] m;
		m = 3'(beats - 4'h1);
		if (inter) begin
			burst_col = start ^ i;
		end else begin
			burst_col = (start & ~m) | (3'(start + i) & m);
		end
	endfunction : burst_col

endpackage : ddr_link_pkg

// ==== ddr_link_if.sv ====
interface ddr_link_if;

	// ************************************************************
	// Command and address pins, driven by the controller
	// ************************************************************
	logic diff_system_clock; // True half of the clock pair
	logic diff_system_clock_n; // Complement half
	logic clock_enable_in;
	logic chip_select_n;
	logic row_strobe_n;
	logic col_strobe_n;
	logic write_enable_n;
	logic [1:0] bank_select;
	logic [12:0] addr;
	logic [8:0] byte_write_mask; // Lane 8 masks the check bits

	// ************************************************************
	// Two-way pins: each party's drive and enable
	// ************************************************************
	logic [63:0] data_lines_host_out;
	logic [7:0] check_bits_host_out;
	logic [8:0] data_strobe_host_out;
	logic host_oe; // Controller drives data, check and strobe
	logic [63:0] data_lines_dev_out;
	logic [7:0] check_bits_dev_out;
	logic [8:0] data_strobe_dev_out;
	logic dev_oe; // Module drives data, check and strobe

	// Resolved levels; an idle bus reads as zero
	logic [63:0] data_lines;
	logic [7:0] check_bits;
	logic [8:0] data_strobe;
	assign data_lines = host_oe ? data_lines_host_out :
		(dev_oe ? data_lines_dev_out : '0);
	assign check_bits = host_oe ? check_bits_host_out :
		(dev_oe ? check_bits_dev_out : '0);
	assign data_strobe = host_oe ? data_strobe_host_out :
		(dev_oe ? data_strobe_dev_out : '0);

	// Controller end
	modport host (output diff_system_clock, diff_system_clock_n,
		clock_enable_in, chip_select_n, row_strobe_n, col_strobe_n,
		write_enable_n, bank_select, addr, byte_write_mask,
		data_lines_host_out, check_bits_host_out, data_strobe_host_out,
		host_oe, input data_lines, check_bits, data_strobe);

	// Memory module end
	modport device (input diff_system_clock, diff_system_clock_n,
		clock_enable_in, chip_select_n, row_strobe_n, col_strobe_n,
		write_enable_n, bank_select, addr, byte_write_mask,
		output data_lines_dev_out, check_bits_dev_out, data_strobe_dev_out,
		dev_oe, input data_lines, check_bits, data_strobe);

endinterface : ddr_link_if

// ==== ddr_ecc_gen.sv ====
module ddr_ecc_gen (
	input wire logic [63:0] data,
	output logic [7:0] check
);

	// ************************************************************
	// Check bits: six position parities, total and even parity
	// ************************************************************
	always_comb begin
		check = '0;
		for (int i = 0; i < ddr_link_pkg::DATA_W; i++) begin
			for (int k = 0; k < 6; k++) begin
				// Bit joins check k when its index has bit k set
				if (i[k]) begin
					check[k] = check[k] ^ data[i];
				end
			end
			check[6] = check[6] ^ data[i];
			if (!i[0]) begin
				check[7] = check[7] ^ data[i];
			end
		end
	end

endmodule : ddr_ecc_gen

// ==== ddr_module_device.sv ====
module ddr_module_device (
	input wire logic clk,
	input wire logic reset_n,
	ddr_link_if.device link,
	output logic [3:0] bank_open,
	output logic [3:0] read_latency_half,
	output logic [3:0] burst_beats,
	output logic interleaved,
	output logic self_refresh,
	output logic power_down,
	output logic burst_active
);

	// ************************************************************
	// Types
	// ************************************************************
	// Burst phase, Gray along idle, read, write
	typedef enum logic [1:0] {
		BURST_IDLE = 2'h0,
		BURST_READ = 2'h1,
		BURST_WRITE = 2'h3
	} burst_t;

	// One sample of every link pin the module reads
	typedef struct packed {
		logic clk_lvl; // Link clock level
		logic cke; // Clock enable
		logic cs_n; // Chip select
		ddr_link_pkg::cmd_t cmd; // Row, column, write strobes
		logic [1:0] bank; // Bank select
		logic [12:0] addr; // Address lines
		logic [8:0] mask; // Byte write masks
		logic [71:0] word; // Check bits over data lines
		logic strobe; // Data strobe, lane 0
	} pins_t;

	// Whole module state
	typedef struct packed {
		pins_t s1; // First synchroniser stage
		pins_t s2; // Second synchroniser stage
		logic clk_prev; // Link clock one sample ago
		logic strobe_prev; // Strobe one sample ago
		burst_t phase; // Burst in flight
		logic [1:0] bank; // Bank of the burst
		logic [10:0] col; // Start column of the burst
		logic ap; // Close bank when burst ends
		logic [3:0] half; // Link half cycles since read
		logic [3:0] beat; // Beats done
		logic [3:0] open; // Open flag per bank
		logic [3:0][12:0] row; // Open row per bank
		logic [3:0] lat; // Read latency in half cycles
		logic [3:0] beats; // Burst length
		logic inter; // Interleaved order
		logic self_ref; // In self-refresh
		logic [71:0] out_word; // Read word on the pins
		logic out_strobe; // Read strobe level
		logic oe; // Module drives the data pins
		logic [63:0][71:0] mem; // Stored words, check lane on top
	} dev_state_t;

	dev_state_t r; // Registered state
	dev_state_t next_r; // Next state
	logic rise; // Link clock rose
	logic fall; // Link clock fell
	logic strobe_edge; // Write strobe flipped
	logic [5:0] idx; // Storage slot of this beat

	// ************************************************************
	// Helpers
	// ************************************************************
	// Storage slot from bank, start column and beat
	function automatic logic [5:0] mem_index(input logic [1:0] bank,
		input logic [10:0] col, input logic [3:0] beat,
		input logic [3:0] beats, input logic inter);
		mem_index = {bank, col[3],
			ddr_link_pkg::burst_col(col[2:0], beat[2:0], beats, inter)};
	endfunction : mem_index

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		next_r = r;
		// Every pin passes two flip-flops first
		next_r.s1 = {link.diff_system_clock, link.clock_enable_in,
			link.chip_select_n, link.row_strobe_n, link.col_strobe_n,
			link.write_enable_n, link.bank_select, link.addr,
			link.byte_write_mask, link.check_bits, link.data_lines,
			link.data_strobe[0]};
		next_r.s2 = r.s1;
		next_r.clk_prev = r.s2.clk_lvl;
		next_r.strobe_prev = r.s2.strobe;
		rise = r.s2.clk_lvl & ~r.clk_prev;
		fall = ~r.s2.clk_lvl & r.clk_prev;
		strobe_edge = r.s2.strobe ^ r.strobe_prev;
		idx = mem_index(r.bank, r.col, r.beat, r.beats, r.inter);

		// Read burst paced by both link clock edges
		if (r.phase == BURST_READ && (rise || fall)) begin
			next_r.half = r.half + 4'h1;
			if (next_r.half == r.lat - 4'h1) begin
				// Preamble: take the bus with strobe low
				next_r.oe = 1'b1;
				next_r.out_strobe = 1'b0;
			end else if (next_r.half == r.lat + r.beats) begin
				// Last beat shown, release the bus
				next_r.oe = 1'b0;
				next_r.phase = BURST_IDLE;
				if (r.ap) begin
					next_r.open[r.bank] = 1'b0;
				end
			end else if (next_r.half >= r.lat) begin
				// Data and strobe change on the clock edge
				next_r.out_word = r.mem[idx];
				next_r.out_strobe = ~r.out_strobe;
				next_r.beat = r.beat + 4'h1;
			end
		end

		// Write burst: one beat per strobe flip
		if (r.phase == BURST_WRITE && strobe_edge) begin
			for (int l = 0; l < ddr_link_pkg::LANES; l++) begin
				// Lane 8 holds the check bits and its own mask
				if (!r.s2.mask[l]) begin
					next_r.mem[idx][l*8 +: 8] = r.s2.word[l*8 +: 8];
				end
			end
			next_r.beat = r.beat + 4'h1;
			if (next_r.beat == r.beats) begin
				next_r.phase = BURST_IDLE;
				if (r.ap) begin
					next_r.open[r.bank] = 1'b0;
				end
			end
		end

		// Commands on the rising edge only
		if (rise) begin
			if (!r.s2.cke) begin
				// Clock stopped; refresh code here enters self-refresh
				if (!r.s2.cs_n && r.s2.cmd == ddr_link_pkg::CMD_REFRESH) begin
					next_r.self_ref = 1'b1;
				end
			end else begin
				next_r.self_ref = 1'b0;
				// Deselected: nothing new, bursts run on
				if (!r.s2.cs_n) begin
					case (r.s2.cmd)
						ddr_link_pkg::CMD_MODE: begin
							// Bank zero holds the mode word
							if (r.s2.bank == 2'h0) begin
								next_r.beats = ddr_link_pkg::beats_of(
									r.s2.addr[ddr_link_pkg::MODE_BL_LSB +: 3]);
								next_r.inter =
									r.s2.addr[ddr_link_pkg::MODE_BT_BIT];
								if (r.s2.addr[ddr_link_pkg::MODE_CL_LSB +: 3]
									== ddr_link_pkg::CL_CODE_25) begin
									next_r.lat = ddr_link_pkg::LAT_HALF_25;
								end else begin
									next_r.lat = ddr_link_pkg::LAT_HALF_2;
								end
							end
						end
						ddr_link_pkg::CMD_ACTIVATE: begin
							// Each bank keeps its own row
							next_r.open[r.s2.bank] = 1'b1;
							next_r.row[r.s2.bank] = r.s2.addr;
						end
						ddr_link_pkg::CMD_PRECHARGE: begin
							if (r.s2.addr[ddr_link_pkg::AP_BIT]) begin
								next_r.open = '0;
							end else begin
								next_r.open[r.s2.bank] = 1'b0;
							end
						end
						ddr_link_pkg::CMD_READ,
						ddr_link_pkg::CMD_WRITE: begin
							// One burst at a time
							if (r.phase == BURST_IDLE) begin
								next_r.phase = (r.s2.cmd == ddr_link_pkg::CMD_READ) ?
									BURST_READ : BURST_WRITE;
								next_r.bank = r.s2.bank;
								next_r.col = {r.s2.addr[ddr_link_pkg::COL_HI_BIT],
									r.s2.addr[9:0]};
								next_r.ap = r.s2.addr[ddr_link_pkg::AP_BIT];
								next_r.half = 4'h0;
								next_r.beat = 4'h0;
							end
						end
						default: begin
							// Refresh and no-op keep the state
						end
					endcase
				end
			end
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0;
			r.lat <= ddr_link_pkg::RESET_LAT;
			r.beats <= ddr_link_pkg::RESET_BEATS;
		end else begin
			r <= next_r;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	// Full 72-bit word: data low, check bits high
	assign link.data_lines_dev_out = r.out_word[63:0];
	assign link.check_bits_dev_out = r.out_word[71:64];
	assign link.data_strobe_dev_out = {9{r.out_strobe}};
	assign link.dev_oe = r.oe;
	assign bank_open = r.open;
	assign read_latency_half = r.lat;
	assign burst_beats = r.beats;
	assign interleaved = r.inter;
	assign self_refresh = r.self_ref;
	assign power_down = ~r.s2.cke & ~r.self_ref;
	assign burst_active = (r.phase != BURST_IDLE);

endmodule : ddr_module_device

// ==== ddr_link_host.sv ====
module ddr_link_host (
	input wire logic clk,
	input wire logic reset_n,
	ddr_link_if.host link,
	input wire logic cmd_valid,
	input wire ddr_link_pkg::cmd_t cmd_op,
	input wire logic [1:0] cmd_bank,
	input wire logic [12:0] cmd_addr,
	output logic cmd_ready,
	input wire logic [63:0] wr_data,
	input wire logic [7:0] wr_mask,
	output logic wr_take,
	output logic rd_valid,
	output logic [63:0] rd_data,
	output logic rd_ecc_error,
	input wire logic power_save,
	input wire logic self_refresh_req,
	output logic mode_ready
);

	// ************************************************************
	// Types and state
	// ************************************************************
	// Controller phase, Gray along idle, command, write, read
	typedef enum logic [1:0] {
		H_IDLE = 2'h0,
		H_CMD = 2'h1,
		H_WRITE = 2'h3,
		H_READ = 2'h2
	} host_t;

	typedef struct packed {
		logic [2:0] div; // Link clock divider
		logic clk_lvl; // Link clock level
		host_t state; // Controller phase
		logic cke; // Clock enable pin
		logic cs_n; // Chip select pin
		ddr_link_pkg::cmd_t cmd; // Strobe pins
		logic [1:0] bank; // Bank select pins
		logic [12:0] addr; // Address pins
		logic [8:0] mask; // Write mask pins
		logic [71:0] word; // Check bits over write data
		logic strobe; // Write strobe level
		logic oe; // Controller drives data pins
		logic mode_set; // Mode word sent
		logic [3:0] beats; // Burst length sent
		logic [3:0] beat; // Beats done
		logic [9:0] ref_cnt; // Refresh interval timer
		logic ref_due; // Refresh owed
		logic [72:0] s1; // Read pins, first stage
		logic [72:0] s2; // Read pins, second stage
		logic strobe_prev; // Read strobe one sample ago
		logic [63:0] rd_data; // Captured read data
		logic rd_valid; // One-cycle read beat pulse
		logic rd_err; // Check bits disagree
	} host_state_t;

	host_state_t r; // Registered state
	host_state_t next_r; // Next state
	logic [7:0] wr_check; // Check bits of write data
	logic [7:0] rd_check; // Check bits recomputed on read
	logic load; // Take the next write word

	// Check-bit makers for both directions
	ddr_ecc_gen u_wr_ecc (.data(wr_data), .check(wr_check));
	ddr_ecc_gen u_rd_ecc (.data(r.s2[64:1]), .check(rd_check));

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		next_r = r;
		next_r.div = r.div + 3'h1;
		// Divide by eight: 80 ns, below the rated rate
		next_r.clk_lvl = (next_r.div < ddr_link_pkg::PH_FALL);
		next_r.rd_valid = 1'b0;
		next_r.s1 = {link.check_bits, link.data_lines, link.data_strobe[0]};
		next_r.s2 = r.s1;
		next_r.strobe_prev = r.s2[0];
		// Accept only with the clock on, refresh paid and mode set or a mode command
		cmd_ready = (r.state == H_IDLE) && (r.div == ddr_link_pkg::PH_DECIDE)
			&& r.cke && !power_save && !r.ref_due
			&& (r.mode_set || cmd_op == ddr_link_pkg::CMD_MODE);
		load = ((r.state == H_CMD) && (r.div == ddr_link_pkg::PH_DECIDE)
			&& (r.cmd == ddr_link_pkg::CMD_WRITE))
			|| ((r.state == H_WRITE) && (r.beat != r.beats)
			&& (r.div == ddr_link_pkg::PH_DECIDE
			|| r.div == ddr_link_pkg::PH_LOAD_B));
		wr_take = load;
		if (load) begin
			// Check bits travel as a ninth masked lane
			next_r.word = {wr_check, wr_data};
			next_r.mask = {&wr_mask, wr_mask};
		end

		case (r.state)
			H_IDLE: begin
				if (r.div == ddr_link_pkg::PH_DECIDE) begin
					next_r.cs_n = 1'b1;
					next_r.cmd = ddr_link_pkg::CMD_NOP;
					next_r.cke = ~power_save;
					if (power_save) begin
						if (self_refresh_req && r.cke) begin
							next_r.cs_n = 1'b0;
							next_r.cmd = ddr_link_pkg::CMD_REFRESH;
						end
					end else if (r.cke && r.ref_due && r.mode_set) begin
						next_r.cs_n = 1'b0;
						next_r.cmd = ddr_link_pkg::CMD_REFRESH;
						next_r.ref_due = 1'b0;
						next_r.state = H_CMD;
					end else if (cmd_valid && cmd_ready) begin
						next_r.cs_n = 1'b0;
						next_r.cmd = cmd_op;
						next_r.bank = cmd_bank;
						next_r.addr = cmd_addr;
						next_r.state = H_CMD;
						if (cmd_op == ddr_link_pkg::CMD_MODE) begin
							// Latency and order ride in the address
							next_r.mode_set = 1'b1;
							next_r.beats = ddr_link_pkg::beats_of(
								cmd_addr[ddr_link_pkg::MODE_BL_LSB +: 3]);
						end
					end
				end
			end
			H_CMD: begin
				if (r.div == ddr_link_pkg::PH_DECIDE) begin
					// Command held one full link clock period
					next_r.cs_n = 1'b1;
					next_r.cmd = ddr_link_pkg::CMD_NOP;
					next_r.beat = 4'h0;
					if (r.cmd == ddr_link_pkg::CMD_WRITE) begin
						next_r.oe = 1'b1;
						next_r.strobe = 1'b0;
						next_r.state = H_WRITE;
					end else if (r.cmd == ddr_link_pkg::CMD_READ) begin
						next_r.state = H_READ;
					end else begin
						next_r.state = H_IDLE;
					end
				end
			end
			H_WRITE: begin
				// Strobe flips mid-beat, data changes on clock edges
				if (r.div == ddr_link_pkg::PH_TOGGLE_A
					|| r.div == ddr_link_pkg::PH_TOGGLE_B) begin
					next_r.strobe = ~r.strobe;
					next_r.beat = r.beat + 4'h1;
				end else if (!load && (r.div == ddr_link_pkg::PH_DECIDE
					|| r.div == ddr_link_pkg::PH_LOAD_B)) begin
					next_r.oe = 1'b0;
					next_r.state = H_IDLE;
				end
			end
			H_READ: begin
				// Catch a beat on each strobe flip
				if (r.s2[0] ^ r.strobe_prev) begin
					next_r.rd_valid = 1'b1;
					next_r.rd_data = r.s2[64:1];
					next_r.rd_err = (rd_check != r.s2[72:65]);
					next_r.beat = r.beat + 4'h1;
					if (next_r.beat == r.beats) begin
						next_r.state = H_IDLE;
					end
				end
			end
			default: begin
				next_r.state = H_IDLE;
			end
		endcase

		// Refresh timer last so a new debt is never lost
		if (!r.cke) begin
			next_r.ref_cnt = 10'h000;
		end else if (r.ref_cnt == ddr_link_pkg::REFRESH_COUNT - 10'h001) begin
			next_r.ref_cnt = 10'h000;
			next_r.ref_due = 1'b1;
		end else begin
			next_r.ref_cnt = r.ref_cnt + 10'h001;
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r <= '0;
			r.cs_n <= 1'b1;
			r.cmd <= ddr_link_pkg::CMD_NOP;
			r.beats <= ddr_link_pkg::RESET_BEATS;
		end else begin
			r <= next_r;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign link.diff_system_clock = r.clk_lvl;
	assign link.diff_system_clock_n = ~r.clk_lvl;
	assign link.clock_enable_in = r.cke;
	assign link.chip_select_n = r.cs_n;
	assign link.row_strobe_n = r.cmd[2];
	assign link.col_strobe_n = r.cmd[1];
	assign link.write_enable_n = r.cmd[0];
	assign link.bank_select = r.bank;
	assign link.addr = r.addr;
	assign link.byte_write_mask = r.mask;
	assign link.data_lines_host_out = r.word[63:0];
	assign link.check_bits_host_out = r.word[71:64];
	assign link.data_strobe_host_out = {9{r.strobe}};
	assign link.host_oe = r.oe;
	assign rd_valid = r.rd_valid;
	assign rd_data = r.rd_data;
	assign rd_ecc_error = r.rd_err;
	assign mode_ready = r.mode_set;

endmodule : ddr_link_host

// ==== ddr_link_chk.sv ====
module ddr_link_chk (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic diff_system_clock,
	input wire logic diff_system_clock_n,
	input wire logic chip_select_n,
	input wire logic row_strobe_n,
	input wire logic col_strobe_n,
	input wire logic write_enable_n,
	input wire logic host_oe,
	input wire logic dev_oe,
	input wire logic [8:0] data_strobe
);
	// ****************
	// Link pin checks
	// ****************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_pair_inverse: assert property (
		diff_system_clock_n == !diff_system_clock)
		else $error("clock pair not inverse");
	// Anchored on the fall: the first high phase after reset is short
	a_link_high: assert property ($fell(diff_system_clock) |->
		!diff_system_clock [*4] ##1 diff_system_clock [*4]
		##1 !diff_system_clock) else $error("link clk period");
	a_cmd_held: assert property ($fell(chip_select_n) |->
		!chip_select_n [*8] ##1 chip_select_n) else $error("command length");
	a_cmd_stable: assert property (!chip_select_n && $past(!chip_select_n) |->
		$stable({row_strobe_n, col_strobe_n, write_enable_n})) else $error("cmd");
	a_idle_nop: assert property (chip_select_n |->
		{row_strobe_n, col_strobe_n, write_enable_n} == 3'h7) else $error("nop");
	a_oe_exclusive: assert property (!(host_oe && dev_oe))
		else $error("both ends drive");
	// Strobe stays low two cycles before its first rise
	a_wr_preamble: assert property ($rose(host_oe) |->
		data_strobe == 9'h0 [*2] ##1 data_strobe == 9'h1ff)
		else $error("write strobe start");
	a_strobe_lanes: assert property (host_oe |->
		data_strobe inside {9'h0, 9'h1ff}) else $error("strobe lanes");
endmodule : ddr_link_chk

// ==== test_ddr_ecc_module_cmd_interface.sv ====
module test_ddr_ecc_module_cmd_interface;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************
	// Bench signals
	// ****************
	logic clk = 0, reset_n = 0, cmd_valid = 0, power_save = 0;
	logic self_refresh_req = 0, cmd_ready, wr_take, rd_valid, rd_ecc_error;
	logic mode_ready, interleaved, self_refresh, power_down, burst_active;
	ddr_link_pkg::cmd_t cmd_op = ddr_link_pkg::CMD_NOP;
	logic [1:0] cmd_bank = 2'h0;
	logic [12:0] cmd_addr = 13'h0;
	logic [63:0] wr_data = 64'h0, rd_data, inv = 64'h0;
	logic [7:0] wr_mask = 8'h0;
	logic [3:0] bank_open, read_latency_half, burst_beats;
	logic [63:0] rd_q [8];
	logic [12:0] m_a [3] = '{13'h021, 13'h06b, 13'h022}; // Mode words
	logic [3:0] m_b [3] = '{4'h2, 4'h8, 4'h4};
	logic [3:0] m_l [3] = '{4'h4, 4'h5, 4'h4};
	int n_errors = 0, total_checks = 0, rcnt = 0, wbeat = 0;
	always #5 clk = ~clk;
	ddr_link_if link ();
	ddr_link_host u_ddr_link_host (.clk, .reset_n, .link(link), .cmd_valid,
		.cmd_op, .cmd_bank, .cmd_addr, .cmd_ready, .wr_data, .wr_mask, .wr_take,
		.rd_valid, .rd_data, .rd_ecc_error, .power_save, .self_refresh_req,
		.mode_ready);
	ddr_module_device u_ddr_module_device (.clk, .reset_n, .link(link),
		.bank_open, .read_latency_half, .burst_beats, .interleaved,
		.self_refresh, .power_down, .burst_active);
	ddr_link_chk u_ddr_link_chk (.clk, .reset_n,
		.diff_system_clock(link.diff_system_clock),
		.diff_system_clock_n(link.diff_system_clock_n),
		.chip_select_n(link.chip_select_n), .row_strobe_n(link.row_strobe_n),
		.col_strobe_n(link.col_strobe_n),
		.write_enable_n(link.write_enable_n), .host_oe(link.host_oe),
		.dev_oe(link.dev_oe), .data_strobe(link.data_strobe));
	function automatic logic [63:0] pat(input int i);
		pat = 64'h0123456789abcdef + 64'(i);
	endfunction : pat
	task chk(input string s, input logic [63:0] g, input logic [63:0] e);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task end_sim;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim
	task automatic wait_on(ref logic s);
		for (int n = 0; n < 400 && s !== 1'b1; n++) @(posedge clk);
	endtask : wait_on
	// Issue one command, then wait for the next idle window
	task issue(input ddr_link_pkg::cmd_t op, input logic [1:0] b,
		input logic [12:0] a);
		cmd_op <= op;
		cmd_bank <= b;
		cmd_addr <= a;
		cmd_valid <= 1'b1;
		@(posedge clk);
		wait_on(cmd_ready);
		cmd_valid <= 1'b0;
		@(posedge clk);
		wait_on(cmd_ready);
		chk("ready", cmd_ready, 1'b1);
	endtask : issue
	// Next write beat after each consumed one
	always @(posedge clk) if (wr_take === 1'b1) begin
		wbeat <= wbeat + 1;
		wr_data <= pat(wbeat + 1) ^ inv;
	end
	always @(posedge clk) if (rd_valid === 1'b1) begin
		rd_q[rcnt[2:0]] <= rd_data;
		rcnt <= rcnt + 1;
		chk("ecc", rd_ecc_error, 1'b0);
	end
	task t_mode(input int i);
		issue(ddr_link_pkg::CMD_MODE, 2'h0, m_a[i]);
		chk("beats", burst_beats, m_b[i]);
		chk("lat", read_latency_half, m_l[i]);
		chk("inter", interleaved, m_a[i][3]);
		chk("moded", mode_ready, 1'b1);
	endtask : t_mode
	task t_banks;
		for (int b = 0; b < 4; b++) begin
			issue(ddr_link_pkg::CMD_ACTIVATE, 2'(b), 13'h1fff);
		end
		chk("open", bank_open, 4'hf);
		issue(ddr_link_pkg::CMD_PRECHARGE, 2'h1, 13'h0);
		chk("pre1", bank_open, 4'hd);
		issue(ddr_link_pkg::CMD_PRECHARGE, 2'h1, 13'h400);
		chk("preall", bank_open, 4'h0);
	endtask : t_banks
	// Two writes, second fully masked, then read from column 2
	task t_rw;
		issue(ddr_link_pkg::CMD_ACTIVATE, 2'h2, 13'h0);
		for (int p = 0; p < 2; p++) begin
			inv = p ? 64'hffffffffffffffff : 64'h0;
			wr_mask <= p ? 8'hff : 8'h00;
			wbeat <= 0;
			wr_data <= pat(0) ^ inv;
			issue(ddr_link_pkg::CMD_WRITE, 2'h2, 13'h0);
		end
		t_read(2);
		chk("autopre", bank_open[2], 1'b0);
	endtask : t_rw
	// Read bank 2 from column 2 in mode word i; slots 4-7 never written
	task t_read(input int i);
		int s;
		t_mode(i);
		rcnt <= 0;
		issue(ddr_link_pkg::CMD_READ, 2'h2, 13'h402);
		for (int n = 0; n < 200 && rcnt < m_b[i]; n++) @(posedge clk);
		chk("rcnt", 64'(rcnt), 64'(m_b[i]));
		chk("idle", burst_active, 1'b0);
		for (int j = 0; j < m_b[i]; j++) begin
			s = m_a[i][3] ? (2 ^ j) : ((2 + j) % 4);
			chk("rd", rd_q[j], (s < 4) ? pat(s) : 64'h0);
		end
	endtask : t_read
	// Host pays a refresh within 900 cycles while idle
	task t_refresh;
		int n;
		for (n = 0; n < 900; n++) begin
			@(posedge clk);
			if (link.chip_select_n === 1'b0 && {link.row_strobe_n,
				link.col_strobe_n, link.write_enable_n}
				=== ddr_link_pkg::CMD_REFRESH) break;
		end
		chk("refresh", 64'(n < 900), 64'h1);
	endtask : t_refresh
	task t_power(input logic sr);
		power_save <= 1'b1;
		self_refresh_req <= sr;
		@(posedge clk);
		if (sr) wait_on(self_refresh);
		else wait_on(power_down);
		chk("save", sr ? self_refresh : power_down, 1'b1);
		chk("cke", link.clock_enable_in, 1'b0);
		power_save <= 1'b0;
		self_refresh_req <= 1'b0;
		@(posedge clk);
		wait_on(cmd_ready);
		chk("wake", {self_refresh, power_down, link.clock_enable_in}, 3'h1);
	endtask : t_power
	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		chk("beats0", burst_beats, 4'h2);
		chk("lat0", read_latency_half, 4'h4);
		for (int i = 0; i < 3; i++) t_mode(i);
		t_banks();
		t_rw();
		t_read(1);
		t_refresh();
		t_power(1'b0);
		t_power(1'b1);
		end_sim();
	end
	// Watchdog for a hung handshake
	initial begin
		#200000;
		n_errors++;
		end_sim();
	end
endmodule : test_ddr_ecc_module_cmd_interface
